// File: design/cpac_channel.v
// priority mode control and word handshake of the direct transfer channel
`timescale 1ns/1ns
`include "cpac_map.vh"
module cpac_channel #(
   parameter DW         = `CPAC_DATA_W,
   parameter AW         = `CPAC_ADDR_W,
   parameter CW         = `CPAC_CNT_W,
   parameter WDW        = `CPAC_WD_W,
   parameter WD_CYCLES  = `CPAC_WD_CYCLES,
   parameter FIFO_DEPTH = `CPAC_FIFO_DEPTH
)(
   input  wire          sys_clk,
   input  wire          rst,
   // processor side
   input  wire          start,
   input  wire          halt,
   input  wire          read_op,
   input  wire [AW-1:0] start_addr,
   input  wire [CW-1:0] word_count,
   output wire          busy,
   output reg           chan_end_ff,
   output reg           ifc_check_ff,
   output reg           excl_mode_ff,
   output wire          timer_hold,
   output wire          intr_hold,
   // main storage side
   output wire          mem_req,
   output wire          mem_write,
   output reg  [AW-1:0] mem_addr_ff,
   output wire [DW-1:0] mem_wdata,
   input  wire [DW-1:0] mem_rdata,
   input  wire          mem_grant,
   input  wire          mem_other_req,
   output wire          mem_excl,
   // external device link
   input  wire          priority_in,
   output reg           command_ff,
   output reg           rd_wr_ff,
   output reg           sync_out_ff,
   input  wire          sync_in,
   input  wire          end_in,
   input  wire [DW-1:0] data_in,
   output reg  [DW-1:0] data_out_ff
);
   reg [1:0]     state_ff;      // sequencer state
   reg [1:0]     nxt_state;
   reg [CW-1:0]  link_left_ff;  // words still to pass over the link
   reg [CW-1:0]  fetch_left_ff; // words still to fetch from storage (write)
   reg           last_grant_ff; // storage cycle taken in the previous clock
   reg           end_req_ff;    // device asked to end, wait for strobe drop
   reg [WDW-1:0] wd_cnt_ff;     // clocks since the last strobe rise
   wire          running;
   wire          wd_expire;
   wire          link_done;
   wire          raise_sync;
   wire          take_in;
   wire          drop_cmd;
   wire          f_in_valid;
   wire          f_in_ready;
   wire [DW-1:0] f_in_data;
   wire          f_out_valid;
   wire          f_out_ready;
   wire [DW-1:0] f_out_data;
   wire          mem_want;
   wire          mem_take;

   assign running = (state_ff == `CPAC_ST_RUN);
   assign busy    = (state_ff != `CPAC_ST_IDLE);

   // exclusive mode freezes the timer and other interrupts for the whole operation
   assign timer_hold = busy & excl_mode_ff;
   assign intr_hold  = busy & excl_mode_ff;

   // storage ownership is only claimed once start processing is over
   assign mem_excl = excl_mode_ff & (running | (state_ff == `CPAC_ST_DRAIN));

   // storage wants a cycle: read drains the fifo, write fills it while words remain
   assign mem_want = rd_wr_ff ? f_out_valid
                              : (running & f_in_ready & (fetch_left_ff != {CW{1'b0}}));
   // shared mode backs off for one clock after a cycle if anyone else is waiting;
   // this is what limits the guaranteed shared rate, the storage arbiter may also
   // hold the grant for its own two-cycle functions
   assign mem_req   = mem_want & ~(~excl_mode_ff & last_grant_ff & mem_other_req);
   // exclusive mode can take a cycle every clock, far above a million words a second
   assign mem_take  = mem_req & mem_grant;
   assign mem_write = rd_wr_ff;
   assign mem_wdata = f_out_data;

   // strobe rises only with command up, acknowledge down and a word or a slot ready
   assign raise_sync = running & command_ff & ~sync_out_ff & ~sync_in & ~end_req_ff
                       & (link_left_ff != {CW{1'b0}})
                       & (rd_wr_ff ? f_in_ready : f_out_valid);
   assign take_in    = sync_out_ff & sync_in;
   assign link_done  = (link_left_ff == {CW{1'b0}}) & ~sync_out_ff;

   // watchdog only runs in exclusive mode; shared mode waits on the device forever
   assign wd_expire = running & excl_mode_ff & (wd_cnt_ff == WD_CYCLES[WDW-1:0] - 1'b1);
   // halt and watchdog drop command at once; word count and device end wait for the strobe
   assign drop_cmd  = running & (halt | wd_expire | link_done | (end_req_ff & ~sync_out_ff));

   // fifo steering by direction
   assign f_in_valid  = rd_wr_ff ? (take_in & running) : mem_take;
   assign f_in_data   = rd_wr_ff ? data_in : mem_rdata;
   assign f_out_ready = rd_wr_ff ? mem_take : raise_sync;

   cpac_fifo #(
      .WIDTH (DW),
      .DEPTH (FIFO_DEPTH),
      .AW    (2)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .flush     (start & ~busy),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (f_in_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // sequencer next state
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         `CPAC_ST_IDLE:
            if (start)
               nxt_state = `CPAC_ST_SETUP;
         `CPAC_ST_SETUP:
            nxt_state = `CPAC_ST_RUN;
         `CPAC_ST_RUN:
            if (drop_cmd)
               nxt_state = `CPAC_ST_DRAIN;
         `CPAC_ST_DRAIN:
            // a read keeps storing buffered words; a write just discards them
            if (!rd_wr_ff || !f_out_valid)
               nxt_state = `CPAC_ST_IDLE;
         default:
            nxt_state = `CPAC_ST_IDLE;
      endcase
   end

   // operation control registers
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_ff      <= `CPAC_ST_IDLE;
         excl_mode_ff  <= 1'b0;
         rd_wr_ff      <= 1'b0;
         command_ff    <= 1'b0;
         ifc_check_ff  <= 1'b0;
         chan_end_ff   <= 1'b0;
         end_req_ff    <= 1'b0;
         link_left_ff  <= {CW{1'b0}};
         fetch_left_ff <= {CW{1'b0}};
         mem_addr_ff   <= {AW{1'b0}};
         last_grant_ff <= 1'b0;
      end
      else
      begin
         state_ff      <= nxt_state;
         chan_end_ff   <= 1'b0;
         last_grant_ff <= mem_take;
         if (state_ff == `CPAC_ST_IDLE && start)
         begin
            // mode is sampled once here and kept until the next start
            excl_mode_ff  <= priority_in;
            rd_wr_ff      <= read_op;
            ifc_check_ff  <= 1'b0;
            end_req_ff    <= 1'b0;
            link_left_ff  <= word_count;
            fetch_left_ff <= word_count;
            mem_addr_ff   <= start_addr;
         end
         if (state_ff == `CPAC_ST_SETUP)
            command_ff <= 1'b1;
         if (drop_cmd)
            command_ff <= 1'b0;
         // expiry leaves the check flag for the stored status word
         if (wd_expire)
            ifc_check_ff <= 1'b1;
         // device end is honoured only while the strobe is up
         if (running && sync_out_ff && end_in)
            end_req_ff <= 1'b1;
         if (mem_take)
            mem_addr_ff <= mem_addr_ff + `CPAC_WORD_BYTES;
         if (mem_take && !rd_wr_ff)
            fetch_left_ff <= fetch_left_ff - 1'b1;
         if (take_in)
            link_left_ff <= link_left_ff - 1'b1;
         if (state_ff == `CPAC_ST_DRAIN && nxt_state == `CPAC_ST_IDLE)
            chan_end_ff <= 1'b1;
      end
   end

   // word strobe and outgoing data
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         sync_out_ff <= 1'b0;
         data_out_ff <= {DW{1'b0}};
      end
      else
      begin
         if (raise_sync)
         begin
            sync_out_ff <= 1'b1;
            if (!rd_wr_ff)
               data_out_ff <= f_out_data;
         end
         // acknowledge or loss of command pulls the strobe down
         if (take_in || drop_cmd || !command_ff)
            sync_out_ff <= 1'b0;
      end
   end

   // watchdog counter: restarts on each strobe rise, idle outside exclusive runs
   always @(posedge sys_clk)
   begin
      if (rst || !running || !excl_mode_ff || raise_sync)
         wd_cnt_ff <= {WDW{1'b0}};
      else
         wd_cnt_ff <= wd_cnt_ff + 1'b1;
   end
endmodule

// File: design/cpac_map.vh
// constants for the channel priority access control block
`ifndef CPAC_MAP_VH
`define CPAC_MAP_VH

// processor clock rate feeding the channel
`define CPAC_CLK_HZ       20000000
// watchdog window on the word strobe, in milliseconds
`define CPAC_WD_NOM_MS    75
`define CPAC_WD_TOL_MS    25
// terminal count of the watchdog, nominal time in cycles
`define CPAC_WD_CYCLES    (`CPAC_WD_NOM_MS * (`CPAC_CLK_HZ / 1000))
// position of the interface control check bit in the stored status word
`define CPAC_CSW_IFC_BIT  46
// widths and depths
`define CPAC_DATA_W       36
`define CPAC_ADDR_W       24
`define CPAC_CNT_W        16
`define CPAC_WD_W         21
`define CPAC_FIFO_DEPTH   4
// sequencer state codes
`define CPAC_ST_IDLE      2'h0
`define CPAC_ST_SETUP     2'h1
`define CPAC_ST_RUN       2'h2
`define CPAC_ST_DRAIN     2'h3
// storage address step per full word
`define CPAC_WORD_BYTES   24'h000004

`endif

// File: design/cpac_fifo.v
// word fifo between the link and main storage
`timescale 1ns/1ns
module cpac_fifo #(
   parameter WIDTH = 36,
   parameter DEPTH = 4,
   parameter AW    = 2
)(
   input  wire             sys_clk,
   input  wire             rst,
   input  wire             flush,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // word storage
   reg [AW-1:0]    wr_ptr_ff;          // next slot to fill
   reg [AW-1:0]    rd_ptr_ff;          // oldest word
   reg [AW:0]      cnt_ff;             // words held
   wire            push;
   wire            pop;

   // full and empty come straight from the count, so they never lie
   assign in_ready  = (cnt_ff != DEPTH[AW:0]);
   assign out_valid = (cnt_ff != {(AW+1){1'b0}});
   assign out_data  = mem_ff[rd_ptr_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // pointer wrap at the depth, which need not be a power of two
   function [AW-1:0] cpac_inc;
      input [AW-1:0] p;
      begin
         cpac_inc = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
      end
   endfunction

   // storage write, no reset needed on the data itself
   always @(posedge sys_clk)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   // pointers and count
   always @(posedge sys_clk)
   begin
      if (rst || flush)
      begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         cnt_ff    <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr_ff <= cpac_inc(wr_ptr_ff);
         if (pop)
            rd_ptr_ff <= cpac_inc(rd_ptr_ff);
         if (push && !pop)
            cnt_ff <= cnt_ff + 1'b1;
         else if (pop && !push)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end
endmodule

// File: dv/cpac_dev.sv
// behavioural model of the external device on the word strobe link
`timescale 1ns/1ns
module cpac_dev (
   input  wire        sys_clk,
   input  wire        sync_out_ff,
   input  wire [35:0] data_out_ff,
   output reg         sync_in,
   output reg         end_in,
   output reg  [35:0] data_in
);
   int          delay   = 2;  // cycles from strobe rise to acknowledge
   int          end_at  = -1; // word index that carries an end request
   int          n_words = 0;  // words acknowledged in this operation
   logic [35:0] rx_q[$];      // words taken off the output lines

   // answer each strobe still up after the set delay, drop only when the strobe drops
   initial
   begin
      sync_in = 1'b0;
      end_in = 1'b0;
      data_in = 36'h0;
      forever
      begin
         @(negedge sys_clk);
         if (sync_out_ff && !sync_in)
         begin
            repeat (delay) @(negedge sys_clk);
            // a strobe withdrawn meanwhile gets no answer
            if (sync_out_ff)
            begin
               rx_q.push_back(data_out_ff);
               data_in = {4'ha, 32'(n_words)};
               end_in = (n_words == end_at);
               sync_in = 1'b1;
               n_words++;
            end
         end
         else if (!sync_out_ff && sync_in)
         begin
            // data no longer held: show a changed pattern, not the old word
            sync_in = 1'b0;
            end_in = 1'b0;
            data_in = ~data_in;
         end
      end
   end
endmodule

// File: dv/cpac_channel_props.sv
// assertions on the ports of the direct transfer channel
`timescale 1ns/1ns
module cpac_chk #(
   parameter WD_CYCLES = 1500000
)(
   input wire sys_clk,
   input wire rst,
   input wire halt,
   input wire busy,
   input wire chan_end_ff,
   input wire ifc_check_ff,
   input wire excl_mode_ff,
   input wire timer_hold,
   input wire intr_hold,
   input wire mem_req,
   input wire mem_grant,
   input wire mem_other_req,
   input wire mem_excl,
   input wire command_ff,
   input wire sync_out_ff,
   input wire sync_in
);
   reg [31:0] wd_cnt_ff; // cycles since the last strobe rise, command up

   // restart on each strobe rise, clear while the command line is down
   always @(posedge sys_clk)
   begin
      if (rst || !command_ff || $rose(sync_out_ff))
         wd_cnt_ff <= 32'h0;
      else
         wd_cnt_ff <= wd_cnt_ff + 32'h1;
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_mode_hold; busy && $past(busy) |-> $stable(excl_mode_ff); endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid-op");
   // a requester that has already left lets the channel go again at once
   property p_backoff;
      mem_req && mem_grant && !excl_mode_ff && mem_other_req |=> !mem_req || !mem_other_req;
   endproperty
   a_backoff: assert property (p_backoff) else $error("back-to-back shared cycle");
   property p_excl_own; command_ff && excl_mode_ff |-> mem_excl; endproperty
   a_excl_own: assert property (p_excl_own) else $error("exclusive ownership missing");
   property p_hold; timer_hold == (busy && excl_mode_ff) && intr_hold == timer_hold; endproperty
   a_hold: assert property (p_hold) else $error("timer or interrupt hold wrong");
   // this counter lags the channel's own by one clock, so the drop is due before it reaches the terminal count
   property p_wd_bound; command_ff && excl_mode_ff |-> wd_cnt_ff < WD_CYCLES; endproperty
   a_wd_bound: assert property (p_wd_bound) else $error("strobe watchdog too late");
   property p_wd_flag; $rose(ifc_check_ff) |-> excl_mode_ff ##[0:1] !command_ff; endproperty
   a_wd_flag: assert property (p_wd_flag) else $error("check flag without drop");
   property p_shared_quiet; command_ff && !excl_mode_ff |-> !ifc_check_ff; endproperty
   a_shared_quiet: assert property (p_shared_quiet) else $error("timeout in shared mode");
   property p_wait; sync_out_ff && !sync_in && !excl_mode_ff && command_ff && !halt |=> sync_out_ff; endproperty
   a_wait: assert property (p_wait) else $error("strobe dropped unanswered");
   property p_end; $fell(command_ff) |-> ##[1:8] chan_end_ff; endproperty
   a_end: assert property (p_end) else $error("no channel end after drop");

   c_excl_b2b: cover property (mem_req && mem_grant && excl_mode_ff ##1 mem_req && mem_grant);
   c_backoff: cover property (mem_req && mem_grant && mem_other_req && !excl_mode_ff);
   c_wd: cover property ($rose(ifc_check_ff));
endmodule

bind cpac_channel cpac_chk #(.WD_CYCLES(WD_CYCLES)) cpac_chk_i (.sys_clk, .rst, .halt, .busy, .chan_end_ff,
   .ifc_check_ff, .excl_mode_ff, .timer_hold, .intr_hold, .mem_req, .mem_grant, .mem_other_req, .mem_excl,
   .command_ff, .sync_out_ff, .sync_in);

// File: dv/tb.sv
// self-checking bench for the channel priority access control block
`timescale 1ns/1ns
module tb;
   reg          sys_clk, rst, start, read_op, priority_in;
   reg          mem_other_req = 1'b1; // another requester always waiting
   reg  [23:0]  start_addr;
   reg  [15:0]  word_count;
   wire         busy, chan_end_ff, ifc_check_ff, excl_mode_ff, timer_hold, intr_hold, mem_req, mem_write;
   wire         mem_excl, command_ff, rd_wr_ff, sync_out_ff, sync_in, end_in;
   wire [23:0]  mem_addr_ff;
   wire [35:0]  mem_wdata, data_in, data_out_ff;
   wire [35:0]  mem_rdata = {12'h0, mem_addr_ff}; // each storage word holds its own address
   int          n_errors = 0, num_checks = 0, i;
   logic [35:0] wq[$], aq[$]; // storage writes seen: data and address

   cpac_channel #(.WD_CYCLES(64)) cpac_channel_i (.sys_clk, .rst, .start, .halt(1'b0), .read_op, .start_addr,
      .word_count, .busy, .chan_end_ff, .ifc_check_ff, .excl_mode_ff, .timer_hold, .intr_hold, .mem_req,
      .mem_write, .mem_addr_ff, .mem_wdata, .mem_rdata, .mem_grant(1'b1), .mem_other_req, .mem_excl,
      .priority_in, .command_ff, .rd_wr_ff, .sync_out_ff, .sync_in, .end_in, .data_in, .data_out_ff);
   cpac_dev cpac_dev_i (.sys_clk, .sync_out_ff, .data_out_ff, .sync_in, .end_in, .data_in);

   // clock of 50 ns
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // log every storage write (grant is always given)
   always @(posedge sys_clk)
   begin
      if (!rst && mem_req && mem_write)
      begin
         wq.push_back(mem_wdata);
         aq.push_back({12'h0, mem_addr_ff});
      end
   end

   task chk(input logic [35:0] got, input logic [35:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one operation; priority line flips right after the start is taken
   task run_op(input logic pri, input logic rd, input logic [23:0] adr, input logic [15:0] cnt, input int dly,
      input int endat);
      int k;
      cpac_dev_i.delay = dly;
      cpac_dev_i.end_at = endat;
      cpac_dev_i.n_words = 0;
      cpac_dev_i.rx_q = {};
      wq = {};
      aq = {};
      priority_in = pri;
      read_op = rd;
      start_addr = adr;
      word_count = cnt;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      priority_in = ~pri;
      k = 0;
      // a strict compare, so an unknown end flag cannot end the wait early
      while (chan_end_ff !== 1'b1 && k < 20000)
      begin
         if (k == 3)
         begin
            chk(timer_hold, pri);
            chk(intr_hold, pri);
            chk(mem_excl, pri);
            chk(rd_wr_ff, rd);
         end
         @(negedge sys_clk);
         k++;
      end
      chk(k < 20000, 1'b1);
      chk(excl_mode_ff, pri);
      @(negedge sys_clk);
   endtask

   // shared write, slow device: waits past the watchdog span without ending
   task t_write_shared;
      run_op(1'b0, 1'b0, 24'h000100, 16'h0003, 100, -1);
      chk(cpac_dev_i.rx_q.size(), 36'h3);
      for (i = 0; i < 3; i++)
         chk(cpac_dev_i.rx_q[i], 36'h100 + 4 * i);
      chk(ifc_check_ff, 1'b0);
   endtask

   // exclusive read, fast device, stored in address order
   task t_read_excl;
      run_op(1'b1, 1'b1, 24'h000200, 16'h0004, 1, -1);
      chk(wq.size(), 36'h4);
      for (i = 0; i < 4; i++)
      begin
         chk(aq[i], 36'h200 + 4 * i);
         chk(wq[i], {4'ha, 32'(i)});
      end
   endtask

   // device ends a shared read after the second word
   task t_end_early;
      run_op(1'b0, 1'b1, 24'h000400, 16'h0005, 2, 1);
      chk(wq.size(), 36'h2);
      chk(wq[1], {4'ha, 32'h1});
   endtask

   // exclusive write with a silent device: watchdog ends it and flags the check
   task t_wd;
      run_op(1'b1, 1'b0, 24'h000300, 16'h0002, 1000, -1);
      chk(ifc_check_ff, 1'b1);
      chk(cpac_dev_i.rx_q.size(), 36'h0);
   endtask

   task summarize;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // main sequence; the silent-device case goes last as its reply never lands
   initial
   begin
      rst = 1'b1;
      start = 1'b0;
      read_op = 1'b0;
      priority_in = 1'b0;
      start_addr = 24'h0;
      word_count = 16'h0;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      t_write_shared();
      t_read_excl();
      t_end_early();
      t_wd();
      summarize();
   end

   // hang guard: all four operations need well under 40000 cycles
   initial
   begin
      #2000000;
      n_errors++;
      summarize();
   end
endmodule
